// file: hw/jac_pkg.sv
package jac_pkg;
  // ****************************************
  // register layout
  // ****************************************
  localparam int JAC_DATA_W = 8;
  localparam int JAC_CH_NUM = 12;
  localparam int JAC_SEL_W = 4;
  localparam int JAC_REINIT_BIT = 3;
  localparam int JAC_CFG_HIGH_BIT = 2;
  localparam int JAC_CFG_LOW_BIT = 0;
  localparam logic JAC_REINIT_RST = 1'h0;
  localparam logic JAC_CFG_HIGH_RST = 1'h0;
  localparam logic JAC_CFG_LOW_RST = 1'h0;
  localparam logic [JAC_DATA_W-1:0] JAC_READ_RST = 8'h00;
  localparam int JAC_SYNC_STAGES = 2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic jitter_fifo_reinit;
    logic jitter_cfg_high;
    logic jitter_cfg_low;
  } jac_ctrl_t;

  localparam jac_ctrl_t JAC_CTRL_RST = '{
    jitter_fifo_reinit: JAC_REINIT_RST,
    jitter_cfg_high: JAC_CFG_HIGH_RST,
    jitter_cfg_low: JAC_CFG_LOW_RST
  };

  typedef struct packed {
    logic active;
    logic depth_32;
    logic desync;
  } jac_mode_t;
endpackage : jac_pkg

// file: hw/jac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module jac_ctrl
  import jac_pkg::*;
#(
  parameter int CH_NUM = JAC_CH_NUM
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_wr_strobe,
  input wire logic [JAC_SEL_W-1:0] reg_chan_sel,
  input wire logic [JAC_DATA_W-1:0] reg_wr_data,
  output logic [JAC_DATA_W-1:0] reg_rd_data,
  output logic [CH_NUM-1:0] ja_active,
  output logic [CH_NUM-1:0] ja_depth_32,
  output logic [CH_NUM-1:0] ja_desync,
  output logic [CH_NUM-1:0] ja_fifo_flush
);

  // ****************************************
  // reset release
  // ****************************************
  logic [JAC_SYNC_STAGES-1:0] rst_sync_r;
  logic [JAC_SYNC_STAGES-1:0] rst_sync_nxt;
  logic rst_n;

  always_comb begin
    rst_sync_nxt = {rst_sync_r[JAC_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
    end
  end

  assign rst_n = rst_sync_r[JAC_SYNC_STAGES-1];

  // ****************************************
  // bus input synchronisers
  // ****************************************
  logic strobe_s1_r;
  logic strobe_s2_r;
  logic strobe_s3_r;
  logic [JAC_SEL_W-1:0] sel_s1_r;
  logic [JAC_SEL_W-1:0] sel_s2_r;
  logic [JAC_DATA_W-1:0] data_s1_r;
  logic [JAC_DATA_W-1:0] data_s2_r;
  logic wr_pulse;
  logic strobe_s1_nxt;
  logic strobe_s2_nxt;
  logic strobe_s3_nxt;
  logic [JAC_SEL_W-1:0] sel_s1_nxt;
  logic [JAC_SEL_W-1:0] sel_s2_nxt;
  logic [JAC_DATA_W-1:0] data_s1_nxt;
  logic [JAC_DATA_W-1:0] data_s2_nxt;

  // plain stage copies, no logic before the second flop
  always_comb begin
    strobe_s1_nxt = reg_wr_strobe;
    strobe_s2_nxt = strobe_s1_r;
    strobe_s3_nxt = strobe_s2_r;
    sel_s1_nxt = reg_chan_sel;
    sel_s2_nxt = sel_s1_r;
    data_s1_nxt = reg_wr_data;
    data_s2_nxt = data_s1_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_s1_r <= 1'b0;
      strobe_s2_r <= 1'b0;
      strobe_s3_r <= 1'b0;
      sel_s1_r <= '0;
      sel_s2_r <= '0;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end else begin
      strobe_s1_r <= strobe_s1_nxt;
      strobe_s2_r <= strobe_s2_nxt;
      strobe_s3_r <= strobe_s3_nxt;
      sel_s1_r <= sel_s1_nxt;
      sel_s2_r <= sel_s2_nxt;
      data_s1_r <= data_s1_nxt;
      data_s2_r <= data_s2_nxt;
    end
  end

  assign wr_pulse = strobe_s2_r && !strobe_s3_r;

  // ****************************************
  // decode functions
  // ****************************************
  function automatic jac_mode_t jac_decode(input jac_ctrl_t c);
    jac_mode_t m;
    m = '0;
    case ({c.jitter_cfg_low, c.jitter_cfg_high})
      2'b00: begin
        m.active = 1'b1;
        m.depth_32 = 1'b0;
      end
      2'b01: begin
        m.active = 1'b1;
        m.depth_32 = 1'b1;
      end
      2'b10: begin
        m.active = 1'b1;
        m.desync = 1'b1;
      end
      default: begin
        // selector 11 bypasses the attenuator
        m.active = 1'b0;
      end
    endcase
    return m;
  endfunction : jac_decode

  function automatic logic [JAC_DATA_W-1:0] jac_pack(input jac_ctrl_t c);
    logic [JAC_DATA_W-1:0] d;
    // bits 7:4 and 1 read as zero
    d = JAC_READ_RST;
    d[JAC_REINIT_BIT] = c.jitter_fifo_reinit;
    d[JAC_CFG_HIGH_BIT] = c.jitter_cfg_high;
    d[JAC_CFG_LOW_BIT] = c.jitter_cfg_low;
    return d;
  endfunction : jac_pack

  // channel address match, shared by write and read
  function automatic logic jac_hit(input logic [JAC_SEL_W-1:0] sel, input int ch);
    return (int'(sel) == ch);
  endfunction : jac_hit

  // ****************************************
  // per-channel control registers
  // ****************************************
  jac_ctrl_t ctrl_r [CH_NUM];
  jac_ctrl_t ctrl_nxt [CH_NUM];
  jac_mode_t mode_nxt [CH_NUM];
  logic [CH_NUM-1:0] active_r;
  logic [CH_NUM-1:0] depth_r;
  logic [CH_NUM-1:0] desync_r;
  logic [CH_NUM-1:0] flush_r;
  logic [CH_NUM-1:0] flush_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < CH_NUM; gi++) begin : g_ch
      always_comb begin
        ctrl_nxt[gi] = ctrl_r[gi];
        if (wr_pulse && jac_hit(sel_s2_r, gi)) begin
          ctrl_nxt[gi].jitter_fifo_reinit = data_s2_r[JAC_REINIT_BIT];
          ctrl_nxt[gi].jitter_cfg_high = data_s2_r[JAC_CFG_HIGH_BIT];
          ctrl_nxt[gi].jitter_cfg_low = data_s2_r[JAC_CFG_LOW_BIT];
        end
        // one flush pulse per zero-to-one change only
        flush_nxt[gi] = ctrl_nxt[gi].jitter_fifo_reinit && !ctrl_r[gi].jitter_fifo_reinit;
        mode_nxt[gi] = jac_decode(ctrl_nxt[gi]);
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_r[gi] <= JAC_CTRL_RST;
          flush_r[gi] <= 1'b0;
          active_r[gi] <= 1'b1;
          depth_r[gi] <= 1'b0;
          desync_r[gi] <= 1'b0;
        end else begin
          ctrl_r[gi] <= ctrl_nxt[gi];
          flush_r[gi] <= flush_nxt[gi];
          active_r[gi] <= mode_nxt[gi].active;
          depth_r[gi] <= mode_nxt[gi].depth_32;
          desync_r[gi] <= mode_nxt[gi].desync;
        end
      end
    end
  endgenerate

  // ****************************************
  // read-back
  // ****************************************
  logic [JAC_DATA_W-1:0] rd_r;
  logic [JAC_DATA_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = JAC_READ_RST;
    for (int i = 0; i < CH_NUM; i++) begin
      if (jac_hit(sel_s2_r, i)) begin
        rd_nxt = jac_pack(ctrl_r[i]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= JAC_READ_RST;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign reg_rd_data = rd_r;
  assign ja_active = active_r;
  assign ja_depth_32 = depth_r;
  assign ja_desync = desync_r;
  assign ja_fifo_flush = flush_r;

endmodule : jac_ctrl
`default_nettype wire

// file: testbench/jac_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks
// ****************************************
module jac_ctrl_chk
  import jac_pkg::*;
#(
  parameter int CH_NUM = JAC_CH_NUM
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_wr_strobe,
  input wire logic [JAC_SEL_W-1:0] reg_chan_sel,
  input wire logic [JAC_DATA_W-1:0] reg_wr_data,
  input wire logic [JAC_DATA_W-1:0] reg_rd_data,
  input wire logic [CH_NUM-1:0] ja_active,
  input wire logic [CH_NUM-1:0] ja_depth_32,
  input wire logic [CH_NUM-1:0] ja_desync,
  input wire logic [CH_NUM-1:0] ja_fifo_flush
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_flush_one_cycle: assert property (|ja_fifo_flush |=> !(|ja_fifo_flush))
    else $error("flush longer than one cycle");
  a_flush_one_chan: assert property ($onehot0(ja_fifo_flush))
    else $error("flush on several channels");
  a_flush_from_write: assert property ($rose(|ja_fifo_flush) |->
    $past(reg_wr_strobe, 2) || $past(reg_wr_strobe, 3) || $past(reg_wr_strobe, 4))
    else $error("flush without write");
  a_depth_when_active: assert property ((ja_depth_32 & ~ja_active) == '0)
    else $error("depth set while bypassed");
  a_desync_when_active: assert property ((ja_desync & ~ja_active) == '0)
    else $error("desync while bypassed");
  a_desync_depth_excl: assert property ((ja_desync & ja_depth_32) == '0)
    else $error("desync with deep fifo");
  a_mode_hold_quiet: assert property (!reg_wr_strobe [*5] |->
    $stable({ja_active, ja_depth_32, ja_desync}))
    else $error("mode changed without write");
  a_rd_spare_zero: assert property (reg_rd_data[7:4] == 4'h0 && !reg_rd_data[1])
    else $error("spare read bits set");
endmodule : jac_ctrl_chk
bind jac_ctrl jac_ctrl_chk #(.CH_NUM(CH_NUM)) u_jac_ctrl_chk (.ref_clk(ref_clk),
  .resetn(resetn), .reg_wr_strobe(reg_wr_strobe), .reg_chan_sel(reg_chan_sel),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .ja_active(ja_active),
  .ja_depth_32(ja_depth_32), .ja_desync(ja_desync), .ja_fifo_flush(ja_fifo_flush));
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import jac_pkg::*;
  logic clk = 0, rn = 0, stb = 0;
  logic [3:0] sel = 0;
  logic [7:0] wd = 0, rd;
  logic [11:0] act, d32, ds, fl, fs, ea, ed, es;
  logic [7:0] m [16] = '{default: 8'h00};
  int err_count = 0, checks_done = 0, cyc = 0;
  jac_ctrl u_jac_ctrl (.ref_clk(clk), .resetn(rn), .reg_wr_strobe(stb), .reg_chan_sel(sel),
    .reg_wr_data(wd), .reg_rd_data(rd), .ja_active(act), .ja_depth_32(d32), .ja_desync(ds),
    .ja_fifo_flush(fl));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [7:0] erd(input logic [3:0] s);
    return (s < 12) ? m[s] : 8'h00;
  endfunction : erd
  task wr(input logic [3:0] s, input logic [7:0] d);
    logic [11:0] ef;
    ef = (s < 12 && !m[s][3] && d[3]) ? (12'h001 << s) : 12'h000;
    if (s < 12) m[s] = d & 8'h0D;
    @(negedge clk);
    sel = s;
    wd = d;
    fs = 0;
    @(negedge clk);
    stb = 1;
    repeat (2) @(negedge clk) fs |= fl;
    stb = 0;
    repeat (5) @(negedge clk) fs |= fl;
    for (int i = 0; i < 12; i++) begin
      ea[i] = !(m[i][0] & m[i][2]);
      ed[i] = !m[i][0] & m[i][2];
      es[i] = m[i][0] & !m[i][2];
    end
    chk(fs, ef);
    chk(act, ea);
    chk(d32, ed);
    chk(ds, es);
    chk({4'h0, rd}, {4'h0, erd(s)});
  endtask : wr
  task final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(negedge clk);
    rn = 1;
    repeat (4) @(negedge clk);
    void'($urandom(89171));
    chk(act, 12'hFFF);
    chk(d32 | ds | fl, 12'h000);
    wr(0, 8'h08);
    wr(0, 8'h08);
    wr(0, 8'h00);
    wr(0, 8'h08);
    $display("reinit test done");
    for (int i = 0; i < 4; i++) wr(3, {5'h00, i[1], 1'b0, i[0]});
    wr(12, 8'hFF);
    wr(15, 8'h0D);
    $display("mode test done");
    repeat (40) wr(4'($urandom), 8'($urandom));
    $display("random test done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
